/* File: i2srp_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module i2srp_asserts (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // serial link
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_o,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n
);
    logic scl_r;
    logic sda_r;
    logic idle_r;
    logic [3:0] rises_r;
    wire start_w = scl && scl_r && sda_r && !sda;
    wire stop_w = scl && scl_r && !sda_r && sda;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////
    // raw frame tracking, independent of the device's synchroniser
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            idle_r <= 1'b1;
            rises_r <= 4'h0;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
            if (start_w) begin
                idle_r <= 1'b0;
                rises_r <= 4'h0;
            end else if (stop_w) begin
                idle_r <= 1'b1;
            end else if (scl && !scl_r && rises_r != 4'hf) begin
                rises_r <= rises_r + 4'h1;
            end
        end
    end
    sequence drive_rise_s;
        $rose(scl) && !dev_sda_oe_n;
    endsequence
    ////////////////////////////////////////
    open_drain_a: assert property (!dev_sda_o && !host_sda_o)
        else $error("data line driven high");
    reset_idle_a: assert property ($rose(hresetn) |-> scl && dev_sda_oe_n)
        else $error("link not idle after reset");
    dev_change_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device changed data while clock high");
    ack_hold_a: assert property (drive_rise_s |-> !dev_sda_oe_n [*8])
        else $error("device data not held across clock high");
    sel_quiet_a: assert property (rises_r < 4'd8 && !idle_r |-> dev_sda_oe_n)
        else $error("device drove during selection byte");
    idle_quiet_a: assert property (idle_r |-> dev_sda_oe_n)
        else $error("device drove after stop");
    scl_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    scl_low_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low phase too short");
endmodule : i2srp_asserts
`default_nettype wire

/* File: i2srp_device.sv */
// Operation
// - slave only, never drives serial clock
// - works up to fast-mode bit rate
// - data changes only while clock low
// - start: data falls while clock high
// - master sends start before every transfer
// - stop: data rises, clock high; ends
// - sample data on clock rising edge
// - selection byte: address msb first, rw
// - address 0x34 strap low, 0x36 high
// - acknowledge matching selection in ninth bit
// - write: next byte is register index, acked
// - single write: data acked, then stop
// - multi-write from any index until stop
// - strap pulled down selects lower address
`timescale 1ns/1ps
`default_nettype none
module i2srp_device import i2srp_pkg::*; (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // serial link
    i2srp_if.device link,
    // strap and fault flags from pins
    input wire logic addr_select_strap,
    input wire logic [7:0] fault_status_in,
    // register image and write events
    output logic [I2SRP_REG_COUNT*8-1:0] reg_image,
    output logic reg_wr_pulse,
    output logic [7:0] reg_wr_index,
    output logic [7:0] reg_wr_data
);
    typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} i2srp_dstate_t;
    typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} i2srp_kind_t;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [10:0] sync_in;
    logic [10:0] sync_out;
    logic scl_d_r;
    logic sda_d_r;
    wire scl_s = sync_out[1];
    wire sda_s = sync_out[0];
    wire [7:0] status_s = sync_out[9:2];
    wire strap_s = sync_out[10];

    assign sync_in = {addr_select_strap, fault_status_in, link.scl, link.sda};

    // idle bus reads high, strap resets low like its pull-down
    i2srp_sync #(.WIDTH(11), .RST_VAL(11'h003)) i2srp_sync_i (
        .clk(hclk),
        .rst_n(hresetn),
        .d(sync_in),
        .q(sync_out)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;

    ////////////////////////////////////////////////////////////////////////
    // protocol state
    i2srp_dstate_t state_r;
    i2srp_kind_t kind_r;
    logic [7:0] shift_r;
    logic [7:0] tx_sh_r;
    logic [2:0] cnt_r;
    logic got_r;
    logic rd_r;
    logic mack_ok_r;
    logic [7:0] ptr_r;
    logic drive_low_r;
    logic [7:0] mem_r [0:I2SRP_REG_COUNT-1];

    // strap pull-down: unconnected pin reads low, lower address
    wire [7:0] own_addr = strap_s ? DEV_ADDR_STRAP_HI : DEV_ADDR_STRAP_LO;
    wire addr_match = (shift_r[7:1] == own_addr[7:1]);
    wire ptr_valid = (ptr_r < 8'(I2SRP_REG_COUNT));
    wire [7:0] rd_byte = ptr_valid ? mem_r[ptr_r[5:0]] : 8'h00;
    wire rx_done = (state_r == S_RX) & scl_fall & got_r & ~start_det & ~stop_det;
    wire wr_fire = rx_done & (kind_r == K_DATA);
    // status is read-only; writes to it or past the map are acked and dropped
    wire wr_ok = wr_fire & ptr_valid & (ptr_r != OFS_FAULT_STATUS);

    // open drain: only ever pulls data low; the clock is never driven
    assign link.dev_sda_o = 1'b0;
    assign link.dev_sda_oe_n = ~drive_low_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= S_IDLE;
            kind_r <= K_ADDR;
            shift_r <= 8'h00;
            tx_sh_r <= 8'h00;
            cnt_r <= 3'h0;
            got_r <= 1'b0;
            rd_r <= 1'b0;
            mack_ok_r <= 1'b0;
            ptr_r <= 8'h00;
            drive_low_r <= 1'b0;
        end else if (stop_det) begin
            state_r <= S_IDLE;
            drive_low_r <= 1'b0;
        end else if (start_det) begin
            state_r <= S_RX;
            kind_r <= K_ADDR;
            cnt_r <= 3'h0;
            got_r <= 1'b0;
            drive_low_r <= 1'b0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    got_r <= 1'b0;
                end
                S_RX: begin
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], sda_s};
                        cnt_r <= cnt_r + 3'h1;
                        got_r <= (cnt_r == 3'h7);
                    end else if (rx_done) begin
                        got_r <= 1'b0;
                        if (kind_r == K_ADDR && !addr_match) begin
                            state_r <= S_IDLE;
                        end else begin
                            state_r <= S_ACK;
                            drive_low_r <= 1'b1;
                        end
                        if (kind_r == K_ADDR) begin
                            rd_r <= shift_r[0];
                        end
                        if (kind_r == K_REG) begin
                            ptr_r <= shift_r;
                        end
                        if (kind_r == K_DATA) begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end
                end
                S_ACK: begin
                    // release after the ninth clock falls, or for a read drive the first data bit
                    if (scl_fall) begin
                        cnt_r <= 3'h0;
                        if (kind_r == K_ADDR && rd_r) begin
                            state_r <= S_TX;
                            tx_sh_r <= rd_byte;
                            drive_low_r <= ~rd_byte[7];
                        end else begin
                            state_r <= S_RX;
                            drive_low_r <= 1'b0;
                            kind_r <= (kind_r == K_ADDR) ? K_REG : K_DATA;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        cnt_r <= cnt_r + 3'h1;
                        if (cnt_r == 3'h7) begin
                            state_r <= S_MACK;
                            drive_low_r <= 1'b0;
                        end else begin
                            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                            drive_low_r <= ~tx_sh_r[6];
                        end
                    end
                end
                S_MACK: begin
                    if (scl_rise) begin
                        mack_ok_r <= ~sda_s;
                        if (!sda_s) begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                    end else if (scl_fall) begin
                        cnt_r <= 3'h0;
                        if (mack_ok_r) begin
                            state_r <= S_TX;
                            tx_sh_r <= rd_byte;
                            drive_low_r <= ~rd_byte[7];
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage
    genvar gi;
    generate
        for (gi = 0; gi < I2SRP_REG_COUNT; gi++) begin : g_reg
            localparam logic [7:0] IDX = 8'(gi);
            localparam logic [7:0] RST = (IDX == OFS_CONFIG_CLOCK_FAULT) ? RST_CONFIG_CLOCK_FAULT :
                (IDX == OFS_CONFIG_SERIAL_INPUT) ? RST_CONFIG_SERIAL_INPUT : RST_OTHER;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    mem_r[gi] <= RST;
                end else if (IDX == OFS_FAULT_STATUS) begin
                    mem_r[gi] <= status_s;
                end else if (wr_ok && ptr_r == IDX) begin
                    mem_r[gi] <= shift_r;
                end
            end
            assign reg_image[gi*8 +: 8] = mem_r[gi];
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg_wr_pulse <= 1'b0;
            reg_wr_index <= 8'h00;
            reg_wr_data <= 8'h00;
        end else begin
            reg_wr_pulse <= wr_ok;
            if (wr_ok) begin
                reg_wr_index <= ptr_r;
                reg_wr_data <= shift_r;
            end
        end
    end
endmodule : i2srp_device
`default_nettype wire

/* File: i2srp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module i2srp_host import i2srp_pkg::*; #(
    parameter int QTR = QTR_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // serial link
    i2srp_if.host link
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} i2srp_hstate_t;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, read data registered in address phase
    logic wr_pend_r;
    logic [7:0] wr_ofs_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic nack_r;
    i2srp_hstate_t state_r;
    wire busy = (state_r != H_IDLE);
    wire addr_ok = hsel & hready & htrans[1];
    wire [31:0] rd_mux = (haddr[7:0] == HOFS_TXDATA) ? {24'h000000, tx_r} :
        (haddr[7:0] == HOFS_RXDATA) ? {24'h000000, rx_r} :
        (haddr[7:0] == HOFS_STATUS) ? {30'h00000000, nack_r, busy} : 32'h00000000;
    wire cmd_go = wr_pend_r & (wr_ofs_r == HOFS_CMD) & ~busy;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            tx_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            wr_ofs_r <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
            if (wr_pend_r && wr_ofs_r == HOFS_TXDATA) begin
                tx_r <= hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit engine, quarter-period enable from a divider
    logic c_start_r;
    logic c_stop_r;
    logic c_xfer_r;
    logic c_rd_r;
    logic c_ack_r;
    logic [15:0] qcnt_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic scl_r;
    logic oe_n_r;
    logic sda_s;
    wire tick = busy & (qcnt_r == 16'h0000);
    wire last_q = tick & (q_r == 2'h3);
    wire last_bit = (bit_r == 4'h8);
    wire out_bit = c_rd_r ? (last_bit ? ~c_ack_r : 1'b1) : (last_bit ? 1'b1 : tx_sh_r[7]);

    i2srp_sync #(.WIDTH(1), .RST_VAL(1'b1)) i2srp_sync_i (
        .clk(hclk),
        .rst_n(hresetn),
        .d(link.sda),
        .q(sda_s)
    );

    // master drives the clock push-pull; the device never stretches it
    assign link.scl = scl_r;
    assign link.host_sda_o = 1'b0;
    assign link.host_sda_oe_n = oe_n_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qcnt_r <= 16'h0000;
            q_r <= 2'h0;
        end else if (!busy || tick) begin
            qcnt_r <= 16'(QTR - 1);
            q_r <= busy ? q_r + 2'h1 : 2'h0;
        end else begin
            qcnt_r <= qcnt_r - 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= H_IDLE;
            {c_start_r, c_stop_r, c_xfer_r, c_rd_r, c_ack_r} <= 5'h00;
            bit_r <= 4'h0;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            rx_r <= 8'h00;
            nack_r <= 1'b0;
            scl_r <= 1'b1;
            oe_n_r <= 1'b1;
        end else if (cmd_go) begin
            c_start_r <= hwdata[CMD_START_BIT];
            c_stop_r <= hwdata[CMD_STOP_BIT];
            c_xfer_r <= hwdata[CMD_WRITE_BIT] | hwdata[CMD_READ_BIT];
            c_rd_r <= hwdata[CMD_READ_BIT];
            c_ack_r <= hwdata[CMD_ACK_BIT];
            tx_sh_r <= tx_r;
            bit_r <= 4'h0;
            state_r <= hwdata[CMD_START_BIT] ? H_START :
                (hwdata[CMD_WRITE_BIT] | hwdata[CMD_READ_BIT]) ? H_BITS :
                hwdata[CMD_STOP_BIT] ? H_STOP : H_IDLE;
        end else if (tick) begin
            unique case (state_r)
                H_IDLE: begin
                    oe_n_r <= 1'b1;
                end
                H_START: begin
                    // data falls while clock high
                    unique case (q_r)
                        2'h0: oe_n_r <= 1'b1;
                        2'h1: scl_r <= 1'b1;
                        2'h2: oe_n_r <= 1'b0;
                        2'h3: scl_r <= 1'b0;
                    endcase
                    if (last_q) begin
                        state_r <= c_xfer_r ? H_BITS : (c_stop_r ? H_STOP : H_IDLE);
                    end
                end
                H_BITS: begin
                    unique case (q_r)
                        2'h0: oe_n_r <= out_bit;
                        2'h1: scl_r <= 1'b1;
                        2'h2: begin
                            if (!last_bit) begin
                                rx_sh_r <= {rx_sh_r[6:0], sda_s};
                            end else if (!c_rd_r) begin
                                nack_r <= sda_s;
                            end
                        end
                        2'h3: scl_r <= 1'b0;
                    endcase
                    if (last_q) begin
                        bit_r <= bit_r + 4'h1;
                        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        if (last_bit) begin
                            if (c_rd_r) begin
                                rx_r <= rx_sh_r;
                            end
                            state_r <= c_stop_r ? H_STOP : H_IDLE;
                        end
                    end
                end
                H_STOP: begin
                    unique case (q_r)
                        2'h0: oe_n_r <= 1'b0;
                        2'h1: scl_r <= 1'b1;
                        2'h2: oe_n_r <= 1'b1;
                        2'h3: scl_r <= 1'b1;
                    endcase
                    if (last_q) begin
                        state_r <= H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : i2srp_host
`default_nettype wire

/* File: i2srp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface i2srp_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    wire sda;
    // open drain with pull-up: low when any enabled driver pulls low
    assign sda = ~((~host_sda_oe_n & ~host_sda_o) | (~dev_sda_oe_n & ~dev_sda_o));
    modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
    modport host (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface : i2srp_if
`default_nettype wire

/* File: i2srp_pkg.sv */
`default_nettype none
package i2srp_pkg;
    // device register map, one byte per index
    localparam int I2SRP_REG_COUNT = 46;
    localparam logic [7:0]
        OFS_CONFIG_CLOCK_FAULT = 8'h00, OFS_CONFIG_SERIAL_INPUT = 8'h01,
        OFS_CONFIG_OUTPUT_MODE = 8'h02, OFS_CONFIG_PROCESSING = 8'h03,
        OFS_CONFIG_MODULATION = 8'h04, OFS_CONFIG_POWER_OUTPUT = 8'h05,
        OFS_MUTE_CONTROL = 8'h06, OFS_MASTER_VOLUME = 8'h07,
        OFS_CHANNEL1_VOLUME = 8'h08, OFS_CHANNEL2_VOLUME = 8'h09,
        OFS_CHANNEL3_VOLUME = 8'h0a, OFS_PRESET_MODE_SELECT_A = 8'h0b,
        OFS_PRESET_MODE_SELECT_B = 8'h0c, OFS_PRESET_MODE_SELECT_C = 8'h0d,
        OFS_CHANNEL1_CONFIG = 8'h0e, OFS_CHANNEL2_CONFIG = 8'h0f,
        OFS_CHANNEL3_CONFIG = 8'h10, OFS_TONE_CONTROL = 8'h11,
        OFS_LIMITER1_ATTACK_RELEASE_RATE = 8'h12, OFS_LIMITER1_ATTACK_RELEASE_THRESHOLD = 8'h13,
        OFS_LIMITER2_ATTACK_RELEASE_RATE = 8'h14, OFS_LIMITER2_ATTACK_RELEASE_THRESHOLD = 8'h15,
        OFS_COEF_RAM_ADDRESS = 8'h16, OFS_COEF_B1_HIGH = 8'h17, OFS_COEF_B1_MID = 8'h18,
        OFS_COEF_B1_LOW = 8'h19, OFS_COEF_B2_HIGH = 8'h1a, OFS_COEF_B2_MID = 8'h1b,
        OFS_COEF_B2_LOW = 8'h1c, OFS_COEF_A1_HIGH = 8'h1d, OFS_COEF_A1_MID = 8'h1e,
        OFS_COEF_A1_LOW = 8'h1f, OFS_COEF_A2_HIGH = 8'h20, OFS_COEF_A2_MID = 8'h21,
        OFS_COEF_A2_LOW = 8'h22, OFS_COEF_B0_HIGH = 8'h23, OFS_COEF_B0_MID = 8'h24,
        OFS_COEF_B0_LOW = 8'h25, OFS_COEF_UPDATE_CONTROL = 8'h26,
        OFS_POWER_CORRECTION_COEF_HIGH = 8'h27, OFS_POWER_CORRECTION_COEF_LOW = 8'h28,
        OFS_DISTORTION_COMP_COEF_HIGH = 8'h29, OFS_DISTORTION_COMP_COEF_LOW = 8'h2a,
        OFS_FAULT_RECOVERY_TIME_HIGH = 8'h2b, OFS_FAULT_RECOVERY_TIME_LOW = 8'h2c,
        OFS_FAULT_STATUS = 8'h2d;
    // reset values
    localparam logic [7:0] RST_CONFIG_CLOCK_FAULT = 8'h63;
    localparam logic [7:0] RST_CONFIG_SERIAL_INPUT = 8'h80;
    localparam logic [7:0] RST_OTHER = 8'h00;
    // bus selection bytes (write form), strap low / high
    localparam logic [7:0] DEV_ADDR_STRAP_LO = 8'h34;
    localparam logic [7:0] DEV_ADDR_STRAP_HI = 8'h36;
    // link timing: fast-mode bit period, quarter period in hclk cycles (rounded up)
    localparam int HCLK_PERIOD_NS = 4;
    localparam int FAST_BIT_PERIOD_NS = 2500;
    localparam int QTR_CYC = (FAST_BIT_PERIOD_NS + 4 * HCLK_PERIOD_NS - 1) / (4 * HCLK_PERIOD_NS);
    // controller registers on the AHB-Lite side
    localparam logic [7:0] HOFS_CMD = 8'h00;
    localparam logic [7:0] HOFS_TXDATA = 8'h04;
    localparam logic [7:0] HOFS_RXDATA = 8'h08;
    localparam logic [7:0] HOFS_STATUS = 8'h0c;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int CMD_WRITE_BIT = 2;
    localparam int CMD_READ_BIT = 3;
    localparam int CMD_ACK_BIT = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NACK_BIT = 1;
endpackage : i2srp_pkg
`default_nettype wire

/* File: i2srp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module i2srp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // async in, synced out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : i2srp_sync
`default_nettype wire

/* File: i2srp_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module i2srp_tb_top import i2srp_pkg::*;;
    localparam logic [7:0] C_W = 8'h1 << CMD_WRITE_BIT;
    localparam logic [7:0] C_SW = C_W | 8'h1 << CMD_START_BIT;
    localparam logic [7:0] C_R = 8'h1 << CMD_READ_BIT;
    localparam logic [7:0] C_RA = C_R | 8'h1 << CMD_ACK_BIT;
    localparam logic [7:0] C_P = 8'h1 << CMD_STOP_BIT;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, strap = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hreadyout, hresp, wr_pulse;
    logic [7:0] fault_in = 8'h00, wr_index, wr_data;
    logic [I2SRP_REG_COUNT*8-1:0] image;
    logic [15:0] exp_q[$];
    int fail_count = 0, comparisons = 0, cycles = 0;
    integer seed = 32'h6c05;
    always #2 hclk = ~hclk;
    i2srp_if i2srp_if_i();
    // short quarter keeps the run small, still above device sync latency
    i2srp_host #(.QTR(8)) i2srp_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link(i2srp_if_i));
    // strap driven low when idle models the pull-down
    i2srp_device i2srp_device_i (.hclk(hclk), .hresetn(hresetn), .link(i2srp_if_i),
        .addr_select_strap(strap), .fault_status_in(fault_in), .reg_image(image),
        .reg_wr_pulse(wr_pulse), .reg_wr_index(wr_index), .reg_wr_data(wr_data));
    i2srp_asserts i2srp_asserts_i (.hclk(hclk), .hresetn(hresetn), .scl(i2srp_if_i.scl),
        .sda(i2srp_if_i.sda), .host_sda_o(i2srp_if_i.host_sda_o),
        .dev_sda_o(i2srp_if_i.dev_sda_o), .dev_sda_oe_n(i2srp_if_i.dev_sda_oe_n));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("response", hresp, 1'b0);
    endtask : ahb
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] tx, output logic [7:0] rx,
        output logic nk);
        logic [31:0] r;
        ahb(1'b1, HOFS_TXDATA, {24'h0, tx}, r);
        ahb(1'b1, HOFS_CMD, {24'h0, cmd}, r);
        r = '1;
        for (int i = 0; i < 400 && r[STAT_BUSY_BIT] !== 1'b0; i++) ahb(1'b0, HOFS_STATUS, 0, r);
        // a command that never finishes counts here, not only at the timeout
        check("busy", r[STAT_BUSY_BIT], 1'b0);
        nk = r[STAT_NACK_BIT];
        ahb(1'b0, HOFS_RXDATA, 0, r);
        rx = r[7:0];
    endtask : xfer
    ////////////////////////////////////////
    // store events are matched against the driver's notes, oldest first
    always @(posedge hclk) begin
        logic [31:0] exp_w;
        cycles++;
        // a store with no note is a mismatch too
        if (wr_pulse === 1'b1) begin
            exp_w = (exp_q.size() > 0) ? {16'h0, exp_q.pop_front()} : 32'hffffffff;
            check("store", {16'h0, wr_index, wr_data}, exp_w);
        end
        if (cycles == 40000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        logic [7:0] rx, idx, d[3];
        logic nk;
        logic [31:0] r;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < I2SRP_REG_COUNT; i++)
            check("reset value", image[8*i+:8],
                i == OFS_CONFIG_CLOCK_FAULT ? RST_CONFIG_CLOCK_FAULT :
                i == OFS_CONFIG_SERIAL_INPUT ? RST_CONFIG_SERIAL_INPUT : RST_OTHER);
        ahb(1'b0, 8'h10, 0, r);
        check("unmapped read", r, 0);
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            strap <= s[0];
            repeat (4) @(posedge hclk);
            for (int a = 0; a < 2; a++) begin
                xfer(C_SW, a ? DEV_ADDR_STRAP_HI : DEV_ADDR_STRAP_LO, rx, nk);
                check("select ack", nk, a != s);
                xfer(C_P, 0, rx, nk);
            end
        end
        strap <= 1'b0;
        $display("test address select done");
        idx = 8'($random(seed)) & 8'h1f;
        xfer(C_SW, DEV_ADDR_STRAP_LO, rx, nk);
        xfer(C_W, idx, rx, nk);
        check("index ack", nk, 0);
        for (int i = 0; i < 3; i++) begin
            d[i] = 8'($random(seed));
            exp_q.push_back({idx + 8'(i), d[i]});
            xfer(C_W, d[i], rx, nk);
            check("data ack", nk, 0);
        end
        xfer(C_P, 0, rx, nk);
        check("pending stores", 32'(exp_q.size()), 0);
        for (int i = 0; i < 3; i++) check("image", image[8*(idx+i)+:8], d[i]);
        $display("test write done");
        xfer(C_SW, DEV_ADDR_STRAP_LO, rx, nk);
        xfer(C_W, idx, rx, nk);
        xfer(C_SW, DEV_ADDR_STRAP_LO | 8'h01, rx, nk);
        check("read select ack", nk, 0);
        for (int i = 0; i < 3; i++) begin
            xfer(i < 2 ? C_RA : C_R, 0, rx, nk);
            check("read data", rx, d[i]);
        end
        xfer(C_P, 0, rx, nk);
        $display("test read done");
        fault_in <= 8'($random(seed));
        xfer(C_SW, DEV_ADDR_STRAP_LO, rx, nk);
        xfer(C_W, OFS_FAULT_STATUS, rx, nk);
        xfer(C_W, ~fault_in, rx, nk);
        // the dropped byte still advanced the index, so set it again
        xfer(C_SW, DEV_ADDR_STRAP_LO, rx, nk);
        xfer(C_W, OFS_FAULT_STATUS, rx, nk);
        xfer(C_SW, DEV_ADDR_STRAP_LO | 8'h01, rx, nk);
        xfer(C_R, 0, rx, nk);
        check("status read", rx, fault_in);
        xfer(C_P, 0, rx, nk);
        check("status image", image[8*OFS_FAULT_STATUS+:8], fault_in);
        $display("test read only done");
        summarize();
    end
endmodule : i2srp_tb_top
`default_nettype wire
